/* rtl/prl_pkg.sv */
// Constants and carriers for register preload and power-up clear logic
package prl_pkg;

    localparam int PRL_NUM_REGS = 10;
    localparam int PRL_CNT_W    = 7;

    // Timing, in ns as printed, and in core_clk cycles
    localparam int PRL_CORE_CLK_NS = 25;
    localparam int PRL_TW_MIN_NS   = 100;
    localparam int PRL_TW_MAX_NS   = 1000;
    localparam int PRL_SETUP_NS    = 25;
    localparam int PRL_TW_MIN_CYC  = (PRL_TW_MIN_NS + PRL_CORE_CLK_NS - 1) / PRL_CORE_CLK_NS;
    localparam int PRL_TW_MAX_CYC  = PRL_TW_MAX_NS / PRL_CORE_CLK_NS;
    localparam int PRL_SETUP_CYC   = (PRL_SETUP_NS + PRL_CORE_CLK_NS - 1) / PRL_CORE_CLK_NS;

    localparam logic [PRL_NUM_REGS-1:0] PRL_REG_RESET = '0;
    localparam logic [PRL_NUM_REGS-1:0] PRL_OE_OFF    = '1;
    localparam logic [PRL_NUM_REGS-1:0] PRL_ONE       = PRL_NUM_REGS'(1);

    // Levels seen on the output pins and which of them the tester forces
    typedef struct packed {
        logic [PRL_NUM_REGS-1:0] level;
        logic [PRL_NUM_REGS-1:0] forced;
    } prl_pin_in_s;

    // What the logic array and fuse map present to the registers
    typedef struct packed {
        logic [PRL_NUM_REGS-1:0] next_state;
        logic [PRL_NUM_REGS-1:0] out_en;
        logic [PRL_NUM_REGS-1:0] invert;
    } prl_array_s;

endpackage : prl_pkg

/* rtl/prl_pulse_meter.sv */
// Edge detector and high-time meter for the device clock pin
`timescale 1ns/1ps
`default_nettype none
module prl_pulse_meter
    import prl_pkg::*;
#(
    parameter int CNT_W = PRL_CNT_W
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Sampled clock pin
    input  wire logic             clk_pin,
    // Edge pulses and measured high time
    output logic                  rise,
    output logic                  fall,
    output logic [CNT_W-1:0]      high_cycles
);

    logic             pin_q;
    logic [CNT_W-1:0] cnt_q;

    assign rise        = clk_pin & ~pin_q;
    assign fall        = ~clk_pin & pin_q;
    assign high_cycles = cnt_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= clk_pin;
        end
    end

    // Saturates so an over-long pulse never wraps into a legal width
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (rise) begin
            cnt_q <= CNT_W'(1);
        end else if (clk_pin && (cnt_q != '1)) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

endmodule : prl_pulse_meter
`default_nettype wire

/* rtl/prl_top.sv */
// Output registers with tester preload and power-up clear
`timescale 1ns/1ps
`default_nettype none
module prl_top
    import prl_pkg::*;
#(
    parameter int TW_MIN_CYC = PRL_TW_MIN_CYC,
    parameter int TW_MAX_CYC = PRL_TW_MAX_CYC,
    parameter int SETUP_CYC  = PRL_SETUP_CYC
) (
    // Clock and power-up reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Device pins seen by the register logic
    input  wire logic                    pld_clk,
    input  wire logic                    preload_entry_high_level,
    input  wire prl_pin_in_s             pin_in,
    // Logic array and fuse map
    input  wire prl_array_s              array_in,
    // Output pins
    output logic [PRL_NUM_REGS-1:0]      io_out,
    output logic [PRL_NUM_REGS-1:0]      io_oe_n,
    // State and status
    output logic [PRL_NUM_REGS-1:0]      reg_state,
    output logic                         preload_active,
    output logic                         preload_err
);

    logic [PRL_NUM_REGS-1:0] reg_q;
    logic [PRL_NUM_REGS-1:0] reg_d;
    logic [PRL_NUM_REGS-1:0] io_out_q;
    logic [PRL_NUM_REGS-1:0] io_oe_n_q;
    logic                    preload_q;
    logic                    err_q;
    logic [3:0]              settle_q;
    logic                    ready;
    logic                    rise;
    logic                    fall;
    logic [PRL_CNT_W-1:0]    high_cycles;
    logic                    clk_edge;
    logic                    one_hot;
    logic                    width_bad;
    logic                    entry_bad;

    prl_pulse_meter #(
        .CNT_W       (PRL_CNT_W)
    ) u_meter (
        .core_clk    (core_clk),
        .rst         (rst),
        .clk_pin     (pld_clk),
        .rise        (rise),
        .fall        (fall),
        .high_cycles (high_cycles)
    );

    // Settling window after the clear; early edges would violate set-up
    assign ready    = (settle_q == 4'(SETUP_CYC));
    assign clk_edge = rise & ready;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            settle_q <= '0;
        end else if (!ready) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    // Exactly one pin forced: only then is a preload target unambiguous
    assign one_hot = (pin_in.forced != '0)
                   && ((pin_in.forced & (pin_in.forced - PRL_ONE)) == '0);

    assign width_bad = preload_q && fall
                     && ((high_cycles < PRL_CNT_W'(TW_MIN_CYC))
                         || (high_cycles > PRL_CNT_W'(TW_MAX_CYC)));
    assign entry_bad = preload_entry_high_level && !preload_q && pld_clk;

    always_comb begin
        reg_d = reg_q;
        if (preload_q) begin
            if (clk_edge && one_hot) begin
                reg_d = (reg_q & ~pin_in.forced)
                      | (pin_in.level & pin_in.forced);
            end
        end else if (clk_edge) begin
            reg_d = array_in.next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_q <= PRL_REG_RESET;
        end else begin
            reg_q <= reg_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            preload_q <= 1'b0;
        end else begin
            preload_q <= preload_entry_high_level;
        end
    end

    // Drivers off during preload so the tester owns the pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_oe_n_q <= PRL_OE_OFF;
        end else if (preload_entry_high_level) begin
            io_oe_n_q <= PRL_OE_OFF;
        end else begin
            io_oe_n_q <= ~array_in.out_en;
        end
    end

    // Pin level follows the register through the programmed polarity
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_out_q <= PRL_REG_RESET;
        end else begin
            io_out_q <= reg_d ^ array_in.invert;
        end
    end

    // Sticky until the next clear; a diagnostic for the tester only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (entry_bad || width_bad || (preload_q && clk_edge && !one_hot)) begin
            err_q <= 1'b1;
        end
    end

    assign io_out         = io_out_q;
    assign io_oe_n        = io_oe_n_q;
    assign reg_state      = reg_q;
    assign preload_active = preload_q;
    assign preload_err    = err_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Reset checks keep the disable off, or they could never fire
    reset_clear_a:
    assert property (disable iff (1'b0)
        rst |=> reg_q == PRL_REG_RESET && io_out_q == PRL_REG_RESET)
        else $error("register not cleared during reset");

    reset_outputs_a:
    assert property (disable iff (1'b0)
        rst |=> io_oe_n_q == PRL_OE_OFF && !preload_q && !err_q)
        else $error("outputs not at reset levels after clear");

    early_edge_a:
    assert property ($fell(rst) |-> reg_q == PRL_REG_RESET ##1 reg_q == PRL_REG_RESET)
        else $error("register changed before set-up window");

    out_polarity_a:
    assert property (!$past(rst) |-> io_out_q == (reg_q ^ $past(array_in.invert)))
        else $error("output level does not follow polarity");

    preload_capture_a:
    assert property (preload_q && clk_edge && one_hot |=>
        reg_q == $past((reg_q & ~pin_in.forced) | (pin_in.level & pin_in.forced)))
        else $error("preload did not capture forced level");

    single_target_a:
    assert property (preload_q && clk_edge && !one_hot |=> reg_q == $past(reg_q) && err_q)
        else $error("ambiguous preload altered registers");

    drivers_off_a:
    assert property (preload_q |-> io_oe_n_q == PRL_OE_OFF)
        else $error("output driven during preload");

    exit_show_a:
    assert property ($fell(preload_q) && !clk_edge |=>
        io_out_q == ($past(reg_q) ^ $past(array_in.invert)))
        else $error("loaded state not shown after exit");

    width_check_a:
    assert property (width_bad |=> err_q [*2])
        else $error("bad preload pulse width not flagged");

    normal_load_a:
    assert property (!preload_q && clk_edge |=> reg_q == $past(array_in.next_state))
        else $error("normal clock did not load next state");

    // Registers only move on an accepted clock event
    state_hold_a:
    assert property (!clk_edge |=> reg_q == $past(reg_q))
        else $error("register changed without a clock event");

    settle_hold_a:
    assert property (!ready |=> reg_q == $past(reg_q))
        else $error("register changed inside set-up window");

    oe_restore_a:
    assert property (!preload_entry_high_level |=> io_oe_n_q == ~$past(array_in.out_en))
        else $error("output enable not restored after preload");

    preload_mirror_a:
    assert property (!rst |=> preload_q == $past(preload_entry_high_level))
        else $error("preload state does not follow control pin");

    entry_flag_a:
    assert property (entry_bad |=> err_q)
        else $error("entry with clock high not flagged");

    width_ok_a:
    assert property (preload_q && fall && !width_bad |=> err_q == $past(err_q))
        else $error("legal preload pulse width flagged");

    err_sticky_a:
    assert property (err_q |=> err_q)
        else $error("error flag dropped without reset");

    preload_capture_c: cover property (preload_q && clk_edge && one_hot ##[1:40] $fell(preload_q));
    normal_load_c:     cover property (!preload_q && clk_edge);
    preload_err_c:     cover property ($rose(err_q));
    entry_bad_c:       cover property (entry_bad);
    width_bad_c:       cover property (width_bad);

endmodule : prl_top
`default_nettype wire

/* bench/prl_tester.sv */
// Behavioural tester that runs preload passes and device clock pulses
`timescale 1ns/1ps
`default_nettype none
module prl_tester
    import prl_pkg::*;
(
    // Clock
    input  wire logic                    core_clk,
    // Device output pins
    input  wire logic [PRL_NUM_REGS-1:0] io_out,
    input  wire logic [PRL_NUM_REGS-1:0] io_oe_n,
    // Pins driven toward the device
    output logic                         pld_clk,
    output logic                         preload_entry_high_level,
    output var prl_pin_in_s              pin_in
);
    logic [PRL_NUM_REGS-1:0] drv_q;
    logic [PRL_NUM_REGS-1:0] frc_q;
    logic [PRL_NUM_REGS-1:0] flt_q;

    initial begin
        pld_clk = 1'b0;
        preload_entry_high_level = 1'b0;
        drv_q = '0;
        frc_q = '0;
        flt_q = 10'h155;
    end

    // Undriven pins wander so a stale level never passes for data
    always @(posedge core_clk) flt_q <= ~flt_q;

    assign pin_in.forced = frc_q;
    assign pin_in.level  = (frc_q & drv_q) | (~frc_q & ~io_oe_n & io_out)
                         | (~frc_q & io_oe_n & flt_q);

    // Every step but the hi-cycle clock pulse lasts at least 4 cycles, 100 ns
    task automatic run(input logic [PRL_NUM_REGS-1:0] mask,
                       input logic [PRL_NUM_REGS-1:0] lvl, input int hi, input bit pre);
        @(posedge core_clk);
        preload_entry_high_level <= pre;
        repeat (4) @(posedge core_clk);
        frc_q <= pre ? mask : '0;
        drv_q <= lvl;
        repeat (4) @(posedge core_clk);
        pld_clk <= 1'b1;
        repeat (hi) @(posedge core_clk);
        pld_clk <= 1'b0;
        repeat (4) @(posedge core_clk);
        frc_q <= '0;
        repeat (4) @(posedge core_clk);
        preload_entry_high_level <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : run

    // Breaks the entry order on purpose: control pin raised with clock high
    task automatic bad_entry();
        @(posedge core_clk);
        pld_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        preload_entry_high_level <= 1'b1;
        repeat (4) @(posedge core_clk);
        pld_clk <= 1'b0;
        repeat (4) @(posedge core_clk);
        preload_entry_high_level <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : bad_entry
endmodule : prl_tester
`default_nettype wire

/* bench/test_prl_top.sv */
// Self-checking bench for register preload and power-up clear
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_prl_top;
    import prl_pkg::*;
    localparam logic [PRL_NUM_REGS-1:0] INV = 10'h2a5;
    logic                    core_clk;
    logic                    rst;
    logic                    pld_clk;
    logic                    preload_entry_high_level;
    prl_pin_in_s             pin_in;
    prl_array_s              array_in;
    logic [PRL_NUM_REGS-1:0] io_out;
    logic [PRL_NUM_REGS-1:0] io_oe_n;
    logic [PRL_NUM_REGS-1:0] reg_state;
    logic                    preload_active;
    logic                    preload_err;
    logic [PRL_NUM_REGS-1:0] exp_q;
    int                      n_mismatch;
    int                      cmp_count;

    prl_top i_prl_top (.core_clk(core_clk), .rst(rst), .pld_clk(pld_clk),
        .preload_entry_high_level(preload_entry_high_level), .pin_in(pin_in),
        .array_in(array_in), .io_out(io_out), .io_oe_n(io_oe_n), .reg_state(reg_state),
        .preload_active(preload_active), .preload_err(preload_err));
    prl_tester i_prl_tester (.core_clk(core_clk), .io_out(io_out), .io_oe_n(io_oe_n),
        .pld_clk(pld_clk), .preload_entry_high_level(preload_entry_high_level),
        .pin_in(pin_in));

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        cyc(20);
        rst <= 1'b0;
        cyc(3);
        `CHK(reg_state, PRL_REG_RESET)
        `CHK(preload_err, 1'b0)
        `CHK(io_out, INV)
        `CHK(io_oe_n, ~array_in.out_en)
    endtask : do_reset

    task automatic t_preload();
        logic [PRL_NUM_REGS-1:0] m;
        exp_q = '0;
        for (int i = 0; i < PRL_NUM_REGS; i++) begin
            m = PRL_ONE << i;
            exp_q[i] = (i % 3) != 0;
            i_prl_tester.run(m, exp_q & m, (i == 0) ? 4 : ((i == 9) ? 40 : 6), 1'b1);
            cyc(2);
            `CHK(reg_state, exp_q)
            `CHK(io_out, exp_q ^ INV)
            `CHK(io_oe_n, ~array_in.out_en)
        end
        `CHK(preload_err, 1'b0)
    endtask : t_preload

    task automatic t_normal();
        @(posedge core_clk);
        array_in.next_state <= 10'h0f3;
        i_prl_tester.run('0, '0, 3, 1'b0);
        cyc(2);
        `CHK(reg_state, 10'h0f3)
        `CHK(io_out, 10'h0f3 ^ INV)
    endtask : t_normal

    // Two pins forced at once must be refused, then a too-short clock
    task automatic t_refuse();
        fork
            i_prl_tester.run(10'h003, 10'h000, 6, 1'b1);
            begin
                cyc(6);
                `CHK(preload_active, 1'b1)
                `CHK(io_oe_n, PRL_OE_OFF)
            end
        join
        cyc(2);
        `CHK(preload_active, 1'b0)
        `CHK(reg_state, 10'h0f3)
        `CHK(preload_err, 1'b1)
        do_reset();
        i_prl_tester.run(10'h010, 10'h010, 3, 1'b1);
        cyc(2);
        `CHK(preload_err, 1'b1)
    endtask : t_refuse

    // Entry with clock high is flagged; the rise before it is a normal load
    task automatic t_bad_entry();
        do_reset();
        i_prl_tester.bad_entry();
        cyc(2);
        `CHK(preload_err, 1'b1)
        `CHK(reg_state, 10'h0f3)
        `CHK(io_out, 10'h0f3 ^ INV)
        `CHK(preload_active, 1'b0)
    endtask : t_bad_entry

    task automatic close_out();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst = 1'b1;
        array_in = '{next_state: 10'h155, out_en: 10'h3ff, invert: INV};
        do_reset();
        t_preload();
        t_normal();
        t_refuse();
        t_bad_entry();
        close_out();
    end

    // Whole run is about 500 cycles
    initial begin
        #(5000 * 25);
        n_mismatch++;
        close_out();
    end
endmodule : test_prl_top
`default_nettype wire
